// *** core/dfc_map.vh ***
// Command code, parameter layouts, reset values and geometry for the
// display function control block.
// Assumes inclusion by bare name from core design files.
`ifndef DFC_MAP_VH
`define DFC_MAP_VH

`define DFC_CMD_CODE        8'hb6
`define DFC_P1_RESET        8'h00
`define DFC_P2_RESET        8'h82
`define DFC_P3_RESET        8'h27
`define DFC_GATE_MODE_HI    3
`define DFC_GATE_MODE_LO    2
`define DFC_SRC_SEL_HI      1
`define DFC_SRC_SEL_LO      0
`define DFC_LC_TYPE_BIT     7
`define DFC_GATE_DIR_BIT    6
`define DFC_SRC_DIR_BIT     5
`define DFC_SCAN_ARR_BIT    4
`define DFC_ISC_HI          3
`define DFC_ISC_LO          0
`define DFC_NL_HI           5
`define DFC_NL_LO           0
`define DFC_GATE_NORMAL     2'b00
`define DFC_GATE_INTERVAL   2'b10
`define DFC_LVL_TOP         2'b00
`define DFC_LVL_BOTTOM      2'b01
`define DFC_LVL_ANALOG_GROUND        2'b10
`define DFC_LVL_HIZ         2'b11
`define DFC_COM_LOW         2'b00
`define DFC_COM_HIGH        2'b01
`define DFC_COM_ANALOG_GROUND        2'b10
`define DFC_NL_MIN          6'h01
`define DFC_NL_MAX          6'h27
`define DFC_LINES_PER_CODE  9'd8
`define DFC_GATE_LAST       9'd319
`define DFC_SRC_LAST        10'd719

`endif

// *** core/dfc_sync3.v ***
// Three-flop synchroniser with agreement filter for one pin level.
// Assumes the pin is asynchronous to mclk_i.
`default_nettype none

module dfc_sync3 #(
    parameter RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire mclk_i,
    input  wire reset_i,
    // Pin and filtered level
    input  wire pin_i,
    output reg  level_o
);

    reg s1_r;
    reg s2_r;
    reg s3_r;

    always @(posedge mclk_i) begin
        if (reset_i) begin
            s1_r    <= RESET_VAL;
            s2_r    <= RESET_VAL;
            s3_r    <= RESET_VAL;
            level_o <= RESET_VAL;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Change counts only when second and third agree
            if (s2_r == s3_r)
                level_o <= s3_r;
        end
    end

endmodule // dfc_sync3

`default_nettype wire

// *** core/dfc_ctrl.v ***
// Display function control: command decode of the three-byte setting,
// the stored fields, and the scan/drive decisions derived from them.
// Assumes host pins asynchronous to mclk_i; frame_start_i and
// polarity_i come from the frame timing logic on mclk_i.
// What this block does
// - Command B6h opens three parameter bytes
// - Byte one: gate mode 3:2, source 1:0
// - Byte two: type, gate, source, arrangement, interval
// - Byte three: six-bit line count, top zero
// - Gate mode 00 normal, 10 interval only
// - Normal scan alternates common; source follows select
// - Partial source level per select and polarity
// - Common low/high per polarity, else ground
// - Source direction: S1 up or S720 down
// - Dot mapping uses direction and colour order
// - Type bit: normally black or white
// - Interval scan every 2*code+1 frames
// - Interval scan inverts polarity per cycle
// - Gate direction: G1 up or reversed
// - Arrangement plus direction choose gate order
// - Line count 8*(code+1), 16 to 320
// - All resets load the documented defaults
// - Command accepted only with extended enable
`default_nettype none
`include "dfc_map.vh"

module dfc_ctrl (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        reset_i,
    input  wire        soft_reset_i,
    // Host parallel command pins
    input  wire        cmd_data_select_i,
    input  wire        write_strobe_n_i,
    input  wire        read_strobe_n_i,
    input  wire [7:0]  data_i,
    input  wire        extended_cmd_enable_i,
    // Display timing context
    input  wire        frame_start_i,
    input  wire        partial_mode_i,
    input  wire        polarity_i,
    input  wire        color_order_swap_i,
    // Stored fields
    output reg  [1:0]  nondisplay_gate_mode_o,
    output reg  [1:0]  nondisplay_source_select_o,
    output reg         liquid_crystal_type_o,
    output reg         gate_direction_o,
    output reg         source_direction_o,
    output reg         scan_arrangement_o,
    output reg  [3:0]  interval_cycle_code_o,
    output reg  [5:0]  driven_line_count_o,
    // Derived drive decisions
    output reg  [8:0]  drive_lines_o,
    output reg  [8:0]  gate_first_o,
    output reg         gate_interleave_o,
    output reg  [9:0]  source_first_o,
    output reg         blue_first_o,
    output reg         nondisplay_scan_o,
    output reg         interval_polarity_o,
    output reg  [1:0]  partial_output_level_o,
    output reg  [1:0]  common_level_o,
    output reg         setting_error_o
);

    localparam ST_IDLE = 2'd0;
    localparam ST_P1   = 2'd1;
    localparam ST_P2   = 2'd2;
    localparam ST_P3   = 2'd3;

    // Filtered host pins
    wire       dcx_s;
    wire       wr_s;
    wire       rd_s;
    wire       ext_s;

    // Data bus delay and strobe edge detection
    reg  [7:0] d1_r;
    reg  [7:0] d2_r;
    reg  [7:0] d3_r;
    reg        wr_q_r;
    wire       wr_rise;
    wire       take_cmd;

    // Parameter sequencer
    reg  [1:0] state_r;
    reg  [1:0] state_nxt;

    // Interval scan and geometry
    reg  [4:0] frame_cnt_r;
    reg        pol_toggle_r;
    wire [4:0] cycle_last;
    wire [8:0] lines_calc;

    // Every host pin except the data bus passes the three-flop agreement filter
    dfc_sync3 #(.RESET_VAL(1'b0)) u_sync_dcx (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .pin_i   (cmd_data_select_i),
        .level_o (dcx_s)
    );

    // Strobe idles high; filter starts high so no false edge
    dfc_sync3 #(.RESET_VAL(1'b1)) u_sync_wr (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .pin_i   (write_strobe_n_i),
        .level_o (wr_s)
    );

    // A write counts only while the read strobe is idle
    dfc_sync3 #(.RESET_VAL(1'b1)) u_sync_rd (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .pin_i   (read_strobe_n_i),
        .level_o (rd_s)
    );

    // Enable starts low: nothing is accepted until it settles
    dfc_sync3 #(.RESET_VAL(1'b0)) u_sync_ext (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .pin_i   (extended_cmd_enable_i),
        .level_o (ext_s)
    );

    // Data bus is delayed to match the strobe's filter latency
    always @(posedge mclk_i) begin
        if (reset_i) begin
            d1_r   <= 8'h00;
            d2_r   <= 8'h00;
            d3_r   <= 8'h00;
            wr_q_r <= 1'b1;
        end else begin
            d1_r   <= data_i;
            d2_r   <= d1_r;
            d3_r   <= d2_r;
            wr_q_r <= wr_s;
        end
    end

    // Latch on write strobe rising edge, read strobe idle
    assign wr_rise  = wr_s & ~wr_q_r & rd_s;
    assign take_cmd = wr_rise & ~dcx_s;

    // Any other command byte aborts a pending parameter run
    always @* begin
        state_nxt = state_r;
        if (take_cmd) begin
            if (d3_r == `DFC_CMD_CODE && ext_s)
                state_nxt = ST_P1;
            else
                state_nxt = ST_IDLE;
        end else if (wr_rise) begin
            case (state_r)
                ST_P1:   state_nxt = ST_P2;
                ST_P2:   state_nxt = ST_P3;
                ST_P3:   state_nxt = ST_IDLE;
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    always @(posedge mclk_i) begin
        if (reset_i || soft_reset_i) begin
            state_r                    <= ST_IDLE;
            nondisplay_gate_mode_o     <= 2'b00;
            nondisplay_source_select_o <= 2'b00;
            liquid_crystal_type_o      <= 1'b1;
            gate_direction_o           <= 1'b0;
            source_direction_o         <= 1'b0;
            scan_arrangement_o         <= 1'b0;
            interval_cycle_code_o      <= 4'h2;
            driven_line_count_o        <= 6'h27;
        end else begin
            state_r <= state_nxt;
            if (wr_rise && dcx_s) begin
                case (state_r)
                    ST_P1: begin
                        nondisplay_gate_mode_o <=
                            d3_r[`DFC_GATE_MODE_HI:`DFC_GATE_MODE_LO];
                        nondisplay_source_select_o <=
                            d3_r[`DFC_SRC_SEL_HI:`DFC_SRC_SEL_LO];
                    end
                    ST_P2: begin
                        liquid_crystal_type_o <= d3_r[`DFC_LC_TYPE_BIT];
                        gate_direction_o      <= d3_r[`DFC_GATE_DIR_BIT];
                        source_direction_o    <= d3_r[`DFC_SRC_DIR_BIT];
                        scan_arrangement_o    <= d3_r[`DFC_SCAN_ARR_BIT];
                        interval_cycle_code_o <=
                            d3_r[`DFC_ISC_HI:`DFC_ISC_LO];
                    end
                    ST_P3: begin
                        driven_line_count_o <= d3_r[`DFC_NL_HI:`DFC_NL_LO];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign cycle_last = {interval_cycle_code_o, 1'b0};
    assign lines_calc = `DFC_LINES_PER_CODE *
                        ({3'b000, driven_line_count_o} + 9'd1);

    // Interval scan frame counter; polarity flips per scan cycle
    always @(posedge mclk_i) begin
        if (reset_i || soft_reset_i) begin
            frame_cnt_r  <= 5'd0;
            pol_toggle_r <= 1'b0;
        end else if (nondisplay_gate_mode_o != `DFC_GATE_INTERVAL) begin
            frame_cnt_r  <= 5'd0;
            pol_toggle_r <= 1'b0;
        end else if (frame_start_i) begin
            if (frame_cnt_r >= cycle_last) begin
                frame_cnt_r  <= 5'd0;
                pol_toggle_r <= ~pol_toggle_r;
            end else begin
                frame_cnt_r <= frame_cnt_r + 5'd1;
            end
        end
    end

    // Geometry follows the stored fields one cycle later
    always @(posedge mclk_i) begin
        if (reset_i) begin
            drive_lines_o          <= 9'd320;
            gate_first_o           <= 9'd0;
            gate_interleave_o      <= 1'b0;
            source_first_o         <= 10'd0;
            blue_first_o           <= 1'b0;
        end else begin
            drive_lines_o <= lines_calc;
            // Gate order within the driven range
            gate_first_o <= gate_direction_o ?
                            lines_calc - 9'd1 : 9'd0;
            gate_interleave_o <= scan_arrangement_o;
            source_first_o <= source_direction_o ?
                              `DFC_SRC_LAST : 10'd0;
            blue_first_o <= source_direction_o ^ color_order_swap_i;
        end
    end

    // Prohibited codes flagged, not corrected: host keeps what it wrote
    always @(posedge mclk_i) begin
        if (reset_i) begin
            setting_error_o        <= 1'b0;
        end else begin
            setting_error_o <=
                nondisplay_gate_mode_o[0] ||
                driven_line_count_o < `DFC_NL_MIN ||
                driven_line_count_o > `DFC_NL_MAX;
        end
    end

    // Gate scan and drive polarity in the non-display area
    always @(posedge mclk_i) begin
        if (reset_i) begin
            nondisplay_scan_o      <= 1'b1;
            interval_polarity_o    <= 1'b0;
        end else if (nondisplay_gate_mode_o == `DFC_GATE_INTERVAL) begin
            nondisplay_scan_o   <= frame_start_i &&
                                   frame_cnt_r >= cycle_last;
            interval_polarity_o <= pol_toggle_r;
        end else begin
            nondisplay_scan_o   <= 1'b1;
            interval_polarity_o <= polarity_i;
        end
    end

    // Source and common levels in the non-display area
    always @(posedge mclk_i) begin
        if (reset_i) begin
            partial_output_level_o <= `DFC_LVL_TOP;
            common_level_o         <= `DFC_COM_LOW;
        end else begin
            // Source level in non-display area
            if (!partial_mode_i)
                partial_output_level_o <= `DFC_LVL_TOP;
            else begin
                case (nondisplay_source_select_o)
                    2'b00: partial_output_level_o <= polarity_i ?
                               `DFC_LVL_TOP : `DFC_LVL_BOTTOM;
                    2'b01: partial_output_level_o <= polarity_i ?
                               `DFC_LVL_BOTTOM : `DFC_LVL_TOP;
                    2'b10: partial_output_level_o <= `DFC_LVL_ANALOG_GROUND;
                    default: partial_output_level_o <= `DFC_LVL_HIZ;
                endcase
            end
            // Common level alternates with polarity unless select bit 1 picks ground
            if (nondisplay_source_select_o[1])
                common_level_o <= `DFC_COM_ANALOG_GROUND;
            else
                common_level_o <= polarity_i ?
                                  `DFC_COM_LOW : `DFC_COM_HIGH;
        end
    end

    // Panel sense is applied downstream; only the stored bit lives here

endmodule // dfc_ctrl

`default_nettype wire

// *** testbench/dfc_monitor.sv ***
// Checker for the display function control block ports.
// Assumes one clock domain, bound onto every dfc_ctrl instance.
`default_nettype none

module dfc_monitor (
    // Clock and reset
    input wire logic       mclk_i,
    input wire logic       reset_i,
    // Inputs watched
    input wire logic       soft_reset_i,
    input wire logic       write_strobe_n_i,
    input wire logic       partial_mode_i,
    input wire logic       polarity_i,
    input wire logic       color_order_swap_i,
    // Outputs watched
    input wire logic [1:0] nondisplay_gate_mode_o,
    input wire logic [1:0] nondisplay_source_select_o,
    input wire logic       liquid_crystal_type_o,
    input wire logic       gate_direction_o,
    input wire logic       source_direction_o,
    input wire logic [3:0] interval_cycle_code_o,
    input wire logic [5:0] driven_line_count_o,
    input wire logic [8:0] drive_lines_o,
    input wire logic [8:0] gate_first_o,
    input wire logic [9:0] source_first_o,
    input wire logic       blue_first_o,
    input wire logic       nondisplay_scan_o,
    input wire logic [1:0] partial_output_level_o,
    input wire logic [1:0] common_level_o,
    input wire logic       setting_error_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    wire logic [1:0]  s = nondisplay_source_select_o;
    wire logic [1:0]  lvl_exp = {s[1], s[0] ^ (~s[1] & ~polarity_i)};
    wire logic [1:0]  com_exp = s[1] ? 2'b10 : {1'b0, ~polarity_i};
    wire logic [8:0]  lines = ({3'h0, driven_line_count_o} + 9'h1) * 9'h8;
    wire logic        nrm = (nondisplay_gate_mode_o == 2'b00);
    wire logic        strobe_idle = write_strobe_n_i && !soft_reset_i;
    wire logic [16:0] fld = {nondisplay_gate_mode_o, s,
        liquid_crystal_type_o, gate_direction_o, source_direction_o,
        interval_cycle_code_o, driven_line_count_o};

    a_line_count: assert property (
        1'b1 |=> drive_lines_o == $past(lines))
        else $error("drive line count wrong");
    a_gate_first: assert property (
        1'b1 |=> gate_first_o ==
        ($past(gate_direction_o) ? $past(lines) - 9'h1 : 9'h0))
        else $error("first gate wrong");
    a_source_first: assert property (
        1'b1 |=> source_first_o ==
        ($past(source_direction_o) ? 10'h2cf : 10'h000))
        else $error("first source wrong");
    a_dot_order: assert property (
        1'b1 |=> blue_first_o ==
        $past(source_direction_o ^ color_order_swap_i))
        else $error("dot order wrong");
    a_prohibit_flag: assert property (
        1'b1 |=> setting_error_o == $past(nondisplay_gate_mode_o[0] ||
        driven_line_count_o == 6'h00 || driven_line_count_o > 6'h27))
        else $error("error flag wrong");
    a_normal_scan: assert property (nrm |=> nondisplay_scan_o)
        else $error("normal scan not held");
    a_partial_level: assert property (
        nrm |=> partial_output_level_o ==
        $past(partial_mode_i ? lvl_exp : 2'b00))
        else $error("partial source level wrong");
    a_common_level: assert property (
        nrm && partial_mode_i |=> common_level_o == $past(com_exp))
        else $error("common level wrong");
    a_field_hold: assert property (
        strobe_idle[*8] |=> $stable(fld))
        else $error("field changed without a write");

    c_interval: cover property (!nrm && nondisplay_scan_o);
    c_error: cover property (setting_error_o);
    c_ground: cover property (partial_mode_i && common_level_o == 2'b10);
endmodule // dfc_monitor

bind dfc_ctrl dfc_monitor u_mon (.*);
`default_nettype wire

// *** testbench/dfc_host.sv ***
// Host model on the parallel command pins of the block.
// Assumes the caller waits for put to return before the next byte.
`default_nettype none

module dfc_host (
    input  wire logic       mclk_i,
    output var  logic       cmd_data_select_o,
    output var  logic       write_strobe_n_o,
    output var  logic       read_strobe_n_o,
    output var  logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_data_select_o = 1'b1;
        write_strobe_n_o  = 1'b1;
        read_strobe_n_o   = 1'b1;
        data_o            = 8'h5a;
    end
    // Held five cycles each side: synchroniser needs four
    task automatic put(input logic dcx, input logic [7:0] b);
        @(posedge mclk_i);
        #1;
        cmd_data_select_o = dcx;
        data_o = b;
        write_strobe_n_o = 1'b0;
        repeat (5) @(posedge mclk_i);
        #1;
        write_strobe_n_o = 1'b1;
        repeat (5) @(posedge mclk_i);
        #1;
        data_o = ~b;
    endtask
endmodule // dfc_host
`default_nettype wire

// *** testbench/display_function_control_test.sv ***
// Self-checking bench for dfc_ctrl driven by the dfc_host model.
// Assumes dfc_monitor is bound onto the design.
`default_nettype none

module display_function_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i, reset_i, soft_reset_i, ext_en, frm, partial, pol, swap;
    wire logic       dcx, wr_n, rd_n, lc, gd, sd, sa, gil, blue, scan, ipol;
    wire logic       err;
    wire logic [7:0] data;
    wire logic [1:0] gm, ss, plvl, clvl;
    wire logic [3:0] interval_cycle_code;
    wire logic [5:0] nl;
    wire logic [8:0] lines, gfirst;
    wire logic [9:0] sfirst;
    wire logic [17:0] fld = {gm, ss, lc, gd, sd, sa, interval_cycle_code, nl};
    int n_errors = 0;
    int cmp_count = 0;

    dfc_host u_host (.mclk_i(mclk_i), .cmd_data_select_o(dcx),
        .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n), .data_o(data));
    dfc_ctrl u_dut (.mclk_i(mclk_i), .reset_i(reset_i),
        .soft_reset_i(soft_reset_i), .cmd_data_select_i(dcx),
        .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .data_i(data),
        .extended_cmd_enable_i(ext_en), .frame_start_i(frm),
        .partial_mode_i(partial), .polarity_i(pol),
        .color_order_swap_i(swap), .nondisplay_gate_mode_o(gm),
        .nondisplay_source_select_o(ss), .liquid_crystal_type_o(lc),
        .gate_direction_o(gd), .source_direction_o(sd),
        .scan_arrangement_o(sa), .interval_cycle_code_o(interval_cycle_code),
        .driven_line_count_o(nl), .drive_lines_o(lines),
        .gate_first_o(gfirst), .gate_interleave_o(gil),
        .source_first_o(sfirst), .blue_first_o(blue),
        .nondisplay_scan_o(scan), .interval_polarity_o(ipol),
        .partial_output_level_o(plvl), .common_level_o(clvl),
        .setting_error_o(err));

    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    task automatic setting(input logic [7:0] p1, p2, p3);
        u_host.put(1'b0, 8'hb6);
        u_host.put(1'b1, p1);
        u_host.put(1'b1, p2);
        u_host.put(1'b1, p3);
        settle();
    endtask

    task automatic t_write();
        setting(8'hf9, 8'h5b, 8'hc5);
        chk(fld, 18'h256c5);
        chk(gil, 32'h1);
        chk({lc, lines, gfirst}, {1'b0, 9'h030, 9'h02f});
        setting(8'h00, 8'h20, 8'h01);
        chk(fld, 18'h00801);
        chk({lines, sfirst, blue}, {9'h10, 10'h2cf, 1'b1});
        swap = 1'b1;
        settle();
        chk(blue, 18'h0);
        swap = 1'b0;
        $display("test write done");
    endtask

    task automatic t_refuse();
        ext_en = 1'b0;
        setting(8'h02, 8'hff, 8'h27);
        chk(fld, 18'h00801);
        ext_en = 1'b1;
        u_host.put(1'b0, 8'h2a);
        u_host.put(1'b1, 8'h03);
        settle();
        chk(fld, 18'h00801);
        u_host.put(1'b0, 8'hb6);
        u_host.put(1'b1, 8'h03);
        settle();
        chk(fld, 18'h0c801);
        $display("test refuse done");
    endtask

    task automatic t_prohib();
        setting(8'h04, 8'h82, 8'h28);
        chk(err, 18'h1);
        setting(8'h00, 8'h82, 8'h00);
        chk(err, 18'h1);
        setting(8'h00, 8'h82, 8'h27);
        chk({err, lines}, {1'b0, 9'h140});
        $display("test prohibited done");
    endtask

    task automatic t_partial();
        logic [1:0] c;
        partial = 1'b1;
        for (int i = 0; i < 8; i++) begin
            c = i[2:1];
            pol = i[0];
            u_host.put(1'b0, 8'hb6);
            u_host.put(1'b1, {6'h00, c});
            settle();
            chk(plvl, c[1] ? c : {1'b0, c[0] ^ ~pol});
            chk(clvl, c[1] ? 2'b10 : {1'b0, ~pol});
        end
        partial = 1'b0;
        $display("test partial done");
    endtask

    task automatic t_interval();
        int f, last, seen;
        logic p;
        f = 0;
        last = 0;
        seen = 0;
        p = 1'b0;
        setting(8'h08, 8'h81, 8'h27);
        for (int c = 0; c < 160; c++) begin
            frm = (c % 4 == 0);
            if (frm)
                f++;
            @(posedge mclk_i);
            #1;
            if (scan === 1'b1) begin
                if (seen > 0) begin
                    chk(f - last, 18'h3);
                    chk(ipol, {31'h0, ~p});
                end
                last = f;
                p = ipol;
                seen++;
            end
        end
        frm = 1'b0;
        chk(seen > 5, 18'h1);
        $display("test interval done");
    endtask

    task automatic t_soft();
        soft_reset_i = 1'b1;
        @(posedge mclk_i);
        #1;
        soft_reset_i = 1'b0;
        settle();
        chk({fld, scan}, {18'h020a7, 1'b1});
        $display("test soft reset done");
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        n_errors++;
        end_sim();
    end

    initial begin
        {soft_reset_i, frm, partial, pol, swap} = 5'h00;
        ext_en = 1'b1;
        reset_i = 1'b1;
        repeat (2) @(posedge mclk_i);
        #1;
        reset_i = 1'b0;
        chk({fld, lines, scan}, {18'h020a7, 9'h140, 1'b1});
        repeat (5) @(posedge mclk_i);
        t_write();
        t_refuse();
        t_prohib();
        t_partial();
        t_interval();
        t_soft();
        end_sim();
    end
endmodule // display_function_control_test
`default_nettype wire
